//--- cos_pkg.sv
/*
  package for the cache-op sequencer: states and timing counts.
  assumes a single processor clock domain; system clock is a divided version.
*/
package cos_pkg;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int unsigned COS_DIV_MIN      = 2;
  localparam int unsigned COS_DIV_MAX      = 8;
  localparam int unsigned COS_DRAIN_MAX    = 3;
  localparam int unsigned COS_DIV_W        = 4;
  localparam int unsigned COS_CNT_W        = 16;

  // ---------------------------------------------------------------
  // states
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    COS_IDLE  = 3'b000,
    COS_WAIT  = 3'b001,
    COS_RUN   = 3'b010,
    COS_WB    = 3'b011,
    COS_FILL  = 3'b100
  } cos_state_t;
endpackage

//--- cos_cache_op_sequencer.sv
/*
  cache-op sequencer: takes maintenance ops from the pipeline, waits for
  higher-priority traffic and drained buffers, runs the op and any write back.
  assumes the pipeline holds op_valid and its fields until op_done.
*/
// Overview of operation
// R1: misses, write backs and external requests beat maintenance ops; counts in cpu cycles.
// R2: pending write-back buffer data is written out before an op begins.
// R3: an instruction miss in the issue cycle is serviced before the op.
// R4: a maintenance op and a data miss never run at the same time.
// R5: outstanding external requests complete before any maintenance op starts.
// R6: data ops wait for empty store and response buffers, up to 3 cycles; the code waits with no limit until both are empty.
// R7: response buffer keeps last miss line until written to the data array.
// R8: store buffer keeps delayed store data until written to the data array.
// R9: writeback-type ops place a dirty outgoing line into the write-back buffer.
// R10: after such a fill, later ops stall until the buffer is written out.
// R11: instruction fill time scales with cpu cycles per system cycle, 2 to 8.
// R12: memory agent sets first-word latency in system cycles.
// R13: block return spans first to last fill word inclusive, system cycles.
// R14: pipeline stalls from op acceptance until op and its write back finish.
`timescale 1ns/1ps
`default_nettype none
module cos_cache_op_sequencer
  import cos_pkg::*;
#(
  parameter int unsigned RUN_CYCLES = 2  // cycles an op holds the cache array
)
(
  input  wire logic                 clock,           // processor clock, 40 MHz
  input  wire logic                 rstn,            // synchronous reset, active low
  input  wire logic                 op_valid,        // maintenance op issued
  input  wire logic                 op_is_data,      // op targets the data cache
  input  wire logic                 op_is_wb,        // op may write back a line
  input  wire logic                 op_is_fill,      // instruction fill op
  input  wire logic                 line_dirty,      // targeted line is dirty
  input  wire logic [COS_DIV_W-1:0] proc_per_sys_cycles, // cpu cycles per sys cycle
  input  wire logic                 imiss_pend,      // instruction miss pending
  input  wire logic                 dmiss_pend,      // data miss pending or active
  input  wire logic                 ext_req_pend,    // external request outstanding
  input  wire logic                 wbb_full,        // write-back buffer holds data
  input  wire logic                 stb_full,        // store buffer holds data
  input  wire logic                 rsp_full,        // response buffer holds data
  input  wire logic                 fill_done,       // last fill word arrived
  output logic                      op_stall,        // stall issuing pipeline
  output logic                      op_done,         // op finished, one cycle
  output logic                      op_active,       // op owns the cache array
  output logic                      wbb_load,        // push dirty line to wb buffer
  output logic                      block_dmiss,     // hold off new data misses
  output logic [COS_CNT_W-1:0]      fill_cycles      // last fill time, cpu cycles
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  cos_state_t           state_q, state_d;
  logic [COS_CNT_W-1:0] cnt_q, cnt_d;
  logic [COS_CNT_W-1:0] fill_q, fill_d;
  logic [COS_DIV_W-1:0] div_q, div_d;
  logic [COS_DIV_W-1:0] sub_q, sub_d;
  logic                 done_q, done_d;
  logic                 wbl_q, wbl_d;
  logic                 clear;

  // ---------------------------------------------------------------
  // op kind, latched at acceptance
  // ---------------------------------------------------------------
  // a late change on the pipeline fields cannot turn a waiting or
  // running op into another kind halfway through
  logic                 kind_data_q, kind_data_d;
  logic                 kind_wb_q, kind_wb_d;
  logic                 kind_fill_q, kind_fill_d;
  logic                 accept;

  always_comb
  begin
    accept      = (state_q == COS_IDLE) && op_valid && !done_q;
    kind_data_d = kind_data_q;
    kind_wb_d   = kind_wb_q;
    kind_fill_d = kind_fill_q;
    if (accept)
    begin
      kind_data_d = op_is_data;
      kind_wb_d   = op_is_wb;
      kind_fill_d = op_is_fill;
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      kind_data_q <= 1'b0;
      kind_wb_q   <= 1'b0;
      kind_fill_q <= 1'b0;
    end
    else
    begin
      kind_data_q <= kind_data_d;
      kind_wb_q   <= kind_wb_d;
      kind_fill_q <= kind_fill_d;
    end
  end

  // nothing of higher priority may be pending; data ops also need drained buffers
  always_comb
  begin
    clear = !imiss_pend && !dmiss_pend && !ext_req_pend && !wbb_full; // [R1] [R2] [R3] [R4] [R5] [R10]
    if (kind_data_q && (stb_full || rsp_full))
      clear = 1'b0; // [R6] [R7] [R8]
  end

  // ---------------------------------------------------------------
  // sequencing
  // ---------------------------------------------------------------
  always_comb
  begin
    state_d = state_q;
    cnt_d   = cnt_q;
    fill_d  = fill_q;
    div_d   = div_q;
    sub_d   = sub_q;
    done_d  = 1'b0;
    wbl_d   = 1'b0;
    case (state_q)
      COS_IDLE:
        if (op_valid && !done_q)
        begin
          state_d = COS_WAIT;
          // clamp the ratio into the supported range
          if (proc_per_sys_cycles < COS_DIV_W'(COS_DIV_MIN))
            div_d = COS_DIV_W'(COS_DIV_MIN); // [R11]
          else if (proc_per_sys_cycles > COS_DIV_W'(COS_DIV_MAX))
            div_d = COS_DIV_W'(COS_DIV_MAX); // [R11]
          else
            div_d = proc_per_sys_cycles;
        end
      COS_WAIT:
        if (clear)
        begin
          cnt_d = COS_CNT_W'(RUN_CYCLES);
          if (kind_fill_q)
          begin
            state_d = COS_FILL;
            cnt_d   = '0;
            sub_d   = '0;
          end
          else
            state_d = COS_RUN;
        end
      COS_RUN:
        if (cnt_q <= COS_CNT_W'(1))
        begin
          if (kind_wb_q && line_dirty)
          begin
            state_d = COS_WB;
            wbl_d   = 1'b1; // [R9]
          end
          else
          begin
            state_d = COS_IDLE;
            done_d  = 1'b1;
          end
        end
        else
          cnt_d = cnt_q - COS_CNT_W'(1);
      COS_WB:
      begin
        // the write back is part of the op: finish once it is in the buffer
        state_d = COS_IDLE;
        done_d  = 1'b1; // [R14]
      end
      COS_FILL:
      begin
        // fill time is counted in system cycles times the ratio
        if (sub_q == div_q - COS_DIV_W'(1))
        begin
          sub_d = '0;
          cnt_d = cnt_q + COS_CNT_W'(div_q); // [R11] [R12] [R13]
        end
        else
          sub_d = sub_q + COS_DIV_W'(1);
        if (fill_done)
        begin
          fill_d  = cnt_q + COS_CNT_W'(sub_q) + COS_CNT_W'(1);
          state_d = COS_IDLE;
          done_d  = 1'b1;
        end
      end
      default:
        state_d = COS_IDLE;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      state_q <= COS_IDLE;
      cnt_q   <= '0;
      fill_q  <= '0;
      div_q   <= COS_DIV_W'(COS_DIV_MIN);
      sub_q   <= '0;
      done_q  <= 1'b0;
      wbl_q   <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      fill_q  <= fill_d;
      div_q   <= div_d;
      sub_q   <= sub_d;
      done_q  <= done_d;
      wbl_q   <= wbl_d;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  // stall covers acceptance through the done cycle
  assign op_stall    = (op_valid && state_q == COS_IDLE && !done_q)
                       || (state_q != COS_IDLE) || done_q; // [R14]
  assign op_active   = (state_q == COS_RUN) || (state_q == COS_WB)
                       || (state_q == COS_FILL);
  assign block_dmiss = op_active; // [R4]
  assign op_done     = done_q;
  assign wbb_load    = wbl_q; // [R9]
  assign fill_cycles = fill_q;
endmodule
`default_nettype wire

//--- cos_checker.sv
/* port checker for the cache-op sequencer.
   assumes it is bound onto the sequencer top. */
`timescale 1ns/1ps
`default_nettype none
module cos_checker (
  input wire logic clock,        // cpu clock
  input wire logic rstn,         // sync reset
  input wire logic op_is_data,   // data op
  input wire logic op_is_wb,     // wb-type op
  input wire logic imiss_pend,   // busy
  input wire logic dmiss_pend,   // busy
  input wire logic ext_req_pend, // busy
  input wire logic wbb_full,     // busy
  input wire logic stb_full,     // busy
  input wire logic rsp_full,     // busy
  input wire logic op_stall,     // out
  input wire logic op_done,      // out
  input wire logic op_active,    // out
  input wire logic wbb_load,     // out
  input wire logic block_dmiss   // out
);
  wire busy = imiss_pend | dmiss_pend | ext_req_pend | wbb_full;
  wire drn  = stb_full | rsp_full;
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  a_busy_blocks: assert property ($rose(op_active) |-> !$past(busy))
    else $error("op ran busy");
  a_drain_data: assert property ($rose(op_active) && op_is_data |-> !$past(drn))
    else $error("no drain");
  a_dmiss_excl: assert property (op_active |-> block_dmiss && !dmiss_pend)
    else $error("dmiss overlap");
  a_stall_hold: assert property (op_active || op_done |-> op_stall)
    else $error("stall low");
  a_done_pulse: assert property (op_done |=> !op_done)
    else $error("done too long");
  a_wb_done: assert property (wbb_load |=> op_done)
    else $error("no done after wb");
  a_wb_kind: assert property (wbb_load |-> op_is_wb)
    else $error("wb on plain op");
  a_run_len: assert property ($rose(op_active) |-> op_active[*2])
    else $error("run short");
  a_done_free: assert property (op_done |-> !op_active)
    else $error("done while active");
  c_data: cover property ($rose(op_active) && op_is_data);
  c_wb: cover property (wbb_load);
  c_wait: cover property (op_stall && !op_active && wbb_full);
endmodule
bind cos_cache_op_sequencer cos_checker u_chk (.clock, .rstn, .op_is_data, .op_is_wb,
  .imiss_pend, .dmiss_pend, .ext_req_pend, .wbb_full, .stb_full, .rsp_full,
  .op_stall, .op_done, .op_active, .wbb_load, .block_dmiss);
`default_nettype wire

//--- cos_partner.sv
/* far side: pipeline misses, external agent and bus memory.
   assumes one cpu clock; busy spells last 7 cycles, a buffer write-out 7 more. */
`timescale 1ns/1ps
`default_nettype none
module cos_partner
#(
  parameter int unsigned memory_first_word_latency = 3, // system cycles to first word
  parameter int unsigned block_return_cycles       = 4  // first to last word, inclusive
)
(
  input  wire logic       clock,     // cpu clock
  input  wire logic       load,      // start busy spell
  input  wire logic [5:0] sel,       // lines to hold busy
  input  wire logic [3:0] div,       // cpu cycles per system cycle, in range
  input  wire logic       op_active, // op owns array
  input  wire logic       wbb_load,  // line pushed to wb buffer
  output logic      [5:0] busy,      // imiss dmiss ext wbb stb rsp
  output logic            fill_done  // last fill word
);
  logic [2:0] cnt_q = 3'h0;
  logic [2:0] wbc_q = 3'h0;
  logic [5:0] sel_q = 6'h00;
  logic [7:0] f_q   = 8'h00;
  logic [7:0] f_last;
  // latency plus block return, both in system cycles, scaled to cpu cycles
  assign f_last = 8'((memory_first_word_latency + block_return_cycles) * div)
                  - 8'h01;
  always_ff @(posedge clock)
  begin
    if (load)
    begin
      cnt_q <= 3'h7;
      sel_q <= sel;
    end
    else if (cnt_q != 3'h0)
      cnt_q <= cnt_q - 3'h1;
    // buffer write-out runs on its own so a new op cannot hide it
    if (wbb_load)
      wbc_q <= 3'h7;
    else if (wbc_q != 3'h0)
      wbc_q <= wbc_q - 3'h1;
    f_q <= op_active ? f_q + 8'h01 : 8'h00;
  end
  assign busy = ((cnt_q != 3'h0) ? sel_q : 6'h00)
                | ((wbc_q != 3'h0) ? 6'h04 : 6'h00);
  assign fill_done = op_active && (f_q == f_last);
endmodule
`default_nettype wire

//--- tb_cache_op_sequencer.sv
/* self-checking bench for the cache-op sequencer.
   assumes the partner model drives all busy lines and the fill return. */
`timescale 1ns/1ps
`default_nettype none
module tb_cache_op_sequencer;
  import cos_pkg::*;
  localparam int unsigned MEM_LAT = 3; // system cycles to the first fill word
  localparam int unsigned BLK_RET = 4; // system cycles, first to last fill word
  logic clock = 0, rstn = 0, op_valid = 0, op_is_data = 0, op_is_wb = 0;
  logic op_is_fill = 0, line_dirty = 0, load = 0, wb_seen = 0, blk;
  logic [COS_DIV_W-1:0] proc_per_sys_cycles = 4'h2, div_e = 4'h2;
  logic imiss_pend, dmiss_pend, ext_req_pend, wbb_full, stb_full, rsp_full, fill_done;
  logic op_stall, op_done, op_active, wbb_load, block_dmiss;
  logic [COS_CNT_W-1:0] fill_cycles, last_fill = '0;
  logic [5:0] sel = 6'h00;
  logic [7:0] lf = 8'h3f;
  logic [16:0] exp_q[$];
  logic [16:0] exp_v;
  int err_count = 0, check_count = 0, n, a, w, exp_n, cyc = 0, wb_free = 0;
  always #12.5 clock = ~clock;
  always @(posedge clock) cyc <= cyc + 1;
  cos_cache_op_sequencer dut (.clock, .rstn, .op_valid, .op_is_data, .op_is_wb, .op_is_fill,
    .line_dirty, .proc_per_sys_cycles, .imiss_pend, .dmiss_pend, .ext_req_pend, .wbb_full,
    .stb_full, .rsp_full, .fill_done, .op_stall, .op_done, .op_active, .wbb_load,
    .block_dmiss, .fill_cycles);
  cos_partner #(.memory_first_word_latency(MEM_LAT), .block_return_cycles(BLK_RET)) pm (
    .clock, .load, .sel, .div(div_e), .op_active, .wbb_load, .fill_done,
    .busy({imiss_pend, dmiss_pend, ext_req_pend, wbb_full, stb_full, rsp_full}));
  function automatic logic [7:0] lfsr_next(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  task automatic finish_test();
    if (err_count == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
    check_count++;
    if (e !== s)
    begin
      err_count++;
      $display("wrong value %s expected %0d seen %0d", nm, e, s);
    end
  endtask
  // monitor: results are taken mid-cycle, where they have settled
  always @(negedge clock)
  begin
    if (wbb_load === 1'b1)
    begin
      wb_seen <= 1'b1;
      wb_free <= cyc + 8; // buffer write-out holds later ops off 7 cycles
    end
    if (op_done === 1'b1)
    begin
      exp_v = exp_q.pop_front();
      chk("wb push", 16'(exp_v[16]), 16'(wb_seen));
      chk("fill cycles", exp_v[15:0], fill_cycles);
      wb_seen <= 1'b0;
    end
  end
  initial
  begin
    repeat (4) @(posedge clock);
    #1 rstn = 1;
    chk("reset outputs", 16'h0000, 16'({op_stall, op_done, op_active, wbb_load, block_dmiss}));
    chk("reset fill", 16'h0000, fill_cycles);
    repeat (30)
    begin
      lf = lfsr_next(lf);
      {op_is_data, op_is_wb, line_dirty} = lf[2:0];
      op_is_fill = lf[3] & ~lf[0];
      proc_per_sys_cycles = lf[6:3];
      if (proc_per_sys_cycles < COS_DIV_W'(COS_DIV_MIN))
        div_e = COS_DIV_W'(COS_DIV_MIN);
      else if (proc_per_sys_cycles > COS_DIV_W'(COS_DIV_MAX))
        div_e = COS_DIV_W'(COS_DIV_MAX);
      else
        div_e = proc_per_sys_cycles;
      sel = lf[7] ? lf[6:1] : 6'h00;
      blk = |sel[5:2] || (op_is_data && |sel[1:0]);
      // the op is taken at the next edge; busy spells then hold it in wait
      a = cyc + 1;
      w = blk ? 7 : 0;
      if (wb_free - a > w)
        w = wb_free - a;
      if (op_is_fill)
      begin
        last_fill = COS_CNT_W'((MEM_LAT + BLK_RET) * div_e);
        exp_n = w + int'(last_fill) + 2;
      end
      else
        exp_n = w + 4 + int'(op_is_wb & line_dirty);
      exp_q.push_back({op_is_wb & line_dirty, last_fill});
      load = 1;
      op_valid = 1;
      @(posedge clock);
      #1 load = 0;
      n = 1;
      while (op_done !== 1'b1 && n < 200)
      begin
        @(posedge clock);
        #1 n++;
      end
      op_valid = 0;
      chk("latency", 16'(exp_n), 16'(n));
      repeat (int'(lf[1:0]) + 1) @(posedge clock);
      #1;
    end
    repeat (3) @(posedge clock);
    chk("queue left", 16'h0000, 16'(exp_q.size()));
    finish_test();
  end
  initial
  begin
    #200us;
    err_count++;
    finish_test();
  end
endmodule
`default_nettype wire
